/* common/cmi_pkg.sv */
// package of constants and carrier types for the crane motion interlock
package cmi_pkg;

  // overload qualification time, in milliseconds
  localparam int unsigned OVL_DELAY_MS  = 1000;
  // system clock rate in hertz
  localparam int unsigned SYS_CLK_HZ    = 25_000_000;
  // overload delay in clock cycles, derived from time and rate
  localparam int unsigned OVL_DELAY_CYC = (SYS_CLK_HZ / 1000) * OVL_DELAY_MS;
  // counter width for the overload delay
  localparam int unsigned OVL_CNT_W     = 25;

  // reset value of every drive output
  localparam logic        DRIVE_OFF     = 1'h0;
  // healthy level of a closed safety switch
  localparam logic        SWITCH_CLOSED = 1'h1;

  // pendant direction commands, one bit per direction
  typedef struct packed {
    logic winch_up;
    logic winch_down;
    logic boom_up;
    logic boom_down;
    logic extend_out;
    logic extend_in;
    logic rotate_cw;
    logic rotate_ccw;
  } cmi_cmd_t;

  // safety switch levels, high means closed
  typedef struct packed {
    logic overload_closed;
    logic two_block_guard_switch;
    logic thermal_closed;
    logic up_limit_clear;
  } cmi_sw_t;

  // overload qualifier states, gray coded
  typedef enum logic [1:0] {
    OVL_HEALTHY = 2'h0,
    OVL_TIMING  = 2'h1,
    OVL_TRIPPED = 2'h3
  } cmi_ovl_state_t;

endpackage : cmi_pkg

/* rtl/cmi_sync2.sv */
// two-flop synchroniser for one asynchronous switch level
`timescale 1ns/1ps
module cmi_sync2
  import cmi_pkg::*;
#(
  parameter logic RESET_VAL = 1'h0  // level shown while in reset
)
(
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic i_clk_en,
  input  wire logic i_async,
  output logic      o_sync
);

  logic meta;  // first stage, read only by the second

  // two stages, frozen while clock enable is low
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      meta   <= RESET_VAL;
      o_sync <= RESET_VAL;
    end
    else if (i_clk_en)
    begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule // cmi_sync2

/* rtl/cmi_interlock.sv */
// crane motion interlock: pendant commands gated by safety switches
`timescale 1ns/1ps
module cmi_interlock
  import cmi_pkg::*;
#(
  parameter int unsigned DELAY_CYC = OVL_DELAY_CYC  // overload qualification cycles
)
(
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic i_clk_en,
  input  wire cmi_cmd_t i_cmd,
  input  wire cmi_sw_t  i_sw,
  input  wire logic i_winch_on_boom,
  output cmi_cmd_t  o_valve,
  output logic      o_pump,
  output logic      o_overload_trip,
  output logic      o_two_block_trip
);

  // elaboration check: counter must hold the delay
  if (DELAY_CYC < 1 || DELAY_CYC >= (1 << OVL_CNT_W))
  begin : g_bad_delay
    $error("DELAY_CYC out of range for counter width");
  end

  // derived sizes and counter limits, fixed at elaboration
  localparam int unsigned NCMD = $bits(cmi_cmd_t);
  localparam int unsigned NSW  = $bits(cmi_sw_t);
  localparam logic [OVL_CNT_W-1:0] DELAY_LAST = OVL_CNT_W'(DELAY_CYC - 1);
  localparam logic [OVL_CNT_W-1:0] CNT_ZERO   = '0;
  localparam logic [OVL_CNT_W-1:0] CNT_ONE    = OVL_CNT_W'(1);

  // internal state and decoded views
  logic [NCMD-1:0]   cmd_sync;    // synchronised pendant levels
  logic [NSW-1:0]    sw_sync;     // synchronised switch levels
  logic              mount_sync;  // synchronised mounting strap
  cmi_cmd_t          cmd_s;       // pendant view as struct
  cmi_sw_t           sw_s;        // switch view as struct
  cmi_ovl_state_t    ovl_state;   // overload qualifier state
  cmi_ovl_state_t    next_ovl_state;
  logic [OVL_CNT_W-1:0] ovl_cnt;  // cycles the overload switch has stayed open, held once tripped
  logic [OVL_CNT_W-1:0] next_ovl_cnt;
  cmi_cmd_t          next_valve;  // gated drive set

  // every pin passes two flops; reset view is all off / switches open
  for (genvar gi = 0; gi < NCMD; gi++)
  begin : g_cmd_sync
    cmi_sync2 #(.RESET_VAL(DRIVE_OFF)) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_clk_en  (i_clk_en),
      .i_async   (i_cmd[gi]),
      .o_sync    (cmd_sync[gi])
    );
  end
  // switches reset to open so nothing damaging runs before they settle
  for (genvar gj = 0; gj < NSW; gj++)
  begin : g_sw_sync
    cmi_sync2 #(.RESET_VAL(~SWITCH_CLOSED)) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_clk_en  (i_clk_en),
      .i_async   (i_sw[gj]),
      .o_sync    (sw_sync[gj])
    );
  end
  // mounting strap may be a switch too, so it is synchronised as well
  cmi_sync2 #(.RESET_VAL(DRIVE_OFF)) u_mount_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_clk_en  (i_clk_en),
    .i_async   (i_winch_on_boom),
    .o_sync    (mount_sync)
  );

  // reinterpret the synchronised bit vectors as named fields
  assign cmd_s = cmi_cmd_t'(cmd_sync);
  assign sw_s  = cmi_sw_t'(sw_sync);

  // trip decode: an open switch is a trip
  wire ovl_open   = (sw_s.overload_closed != SWITCH_CLOSED);
  wire tb_open    = (sw_s.two_block_guard_switch != SWITCH_CLOSED);
  wire therm_open = (sw_s.thermal_closed != SWITCH_CLOSED);
  wire limit_hit  = (sw_s.up_limit_clear != SWITCH_CLOSED);
  // overload blocks boom down only once qualified
  wire ovl_qual   = ovl_open && (ovl_state == OVL_TRIPPED);
  // two-block spares boom down when the winch rides the boom
  wire tb_bd      = tb_open && !mount_sync;
  wire damage_blk = ovl_open || tb_open;

  // opposing pairs: both pressed means neither runs
  wire wu_req = cmd_s.winch_up   && !cmd_s.winch_down;
  wire wd_req = cmd_s.winch_down && !cmd_s.winch_up;
  wire bu_req = cmd_s.boom_up    && !cmd_s.boom_down;
  wire bd_req = cmd_s.boom_down  && !cmd_s.boom_up;
  wire eo_req = cmd_s.extend_out && !cmd_s.extend_in;
  wire ei_req = cmd_s.extend_in  && !cmd_s.extend_out;
  wire cw_req = cmd_s.rotate_cw  && !cmd_s.rotate_ccw;
  wire cc_req = cmd_s.rotate_ccw && !cmd_s.rotate_cw;

  // gated outputs; each function independent so several may run
  always_comb
  begin
    next_valve            = '0;
    // hoist up coil: stopped by trips and by a hot motor
    next_valve.winch_up   = wu_req && !damage_blk && !therm_open;
    // hoist down coil: never gated, even when hot
    next_valve.winch_down = wd_req;
    // boom up: only the up limit stops it, trips never do
    next_valve.boom_up    = bu_req && !limit_hit;
    next_valve.boom_down  = bd_req && !ovl_qual && !tb_bd;
    next_valve.extend_out = eo_req && !damage_blk;
    next_valve.extend_in  = ei_req;
    next_valve.rotate_cw  = cw_req;
    next_valve.rotate_ccw = cc_req;
  end

  // any hydraulic valve (not the hoist coils) runs the pump
  wire next_pump = next_valve.boom_up   || next_valve.boom_down ||
                   next_valve.extend_out || next_valve.extend_in ||
                   next_valve.rotate_cw  || next_valve.rotate_ccw;

  // overload qualifier: count continuous open time
  always_comb
  begin
    next_ovl_state = ovl_state;
    next_ovl_cnt   = ovl_cnt;
    case (ovl_state)
      OVL_HEALTHY:
      begin
        next_ovl_cnt = CNT_ZERO;
        if (ovl_open)
        begin
          // spike may clear before the delay ends
          next_ovl_state = (DELAY_LAST == CNT_ZERO) ? OVL_TRIPPED : OVL_TIMING;
          next_ovl_cnt   = CNT_ONE;
        end
      end
      // counting continuous open time; any close restarts
      OVL_TIMING:
      begin
        if (!ovl_open)
        begin
          next_ovl_state = OVL_HEALTHY;
          next_ovl_cnt   = CNT_ZERO;
        end
        else if (ovl_cnt >= DELAY_LAST)
          next_ovl_state = OVL_TRIPPED;
        else
          next_ovl_cnt = ovl_cnt + CNT_ONE;
      end
      // qualified: held until the switch closes again
      OVL_TRIPPED:
      begin
        if (!ovl_open)
        begin
          next_ovl_state = OVL_HEALTHY;
          next_ovl_cnt   = CNT_ZERO;
        end
      end
      // unused code: fall back to healthy
      default:
      begin
        next_ovl_state = OVL_HEALTHY;
        next_ovl_cnt   = CNT_ZERO;
      end
    endcase
  end

  // qualifier registers
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      ovl_state <= OVL_HEALTHY;
      ovl_cnt   <= CNT_ZERO;
    end
    else if (i_clk_en)
    begin
      ovl_state <= next_ovl_state;
      ovl_cnt   <= next_ovl_cnt;
    end
  end

  // output registers, all off in reset
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_valve          <= '0;
      o_pump           <= DRIVE_OFF;
      o_overload_trip  <= DRIVE_OFF;
      o_two_block_trip <= DRIVE_OFF;
    end
    else if (i_clk_en)
    begin
      o_valve          <= next_valve;
      o_pump           <= next_pump;
      o_overload_trip  <= ovl_open;
      o_two_block_trip <= tb_open;
    end
  end

endmodule // cmi_interlock

/* bench/cmi_checker.sv */
// port checker for the crane motion interlock
`timescale 1ns/1ps
module cmi_checker
  import cmi_pkg::*;
#(
  parameter int unsigned DELAY_CYC = OVL_DELAY_CYC  // overload qualification cycles
)
(
  input wire logic     i_sys_clk,
  input wire logic     i_reset,
  input wire logic     i_clk_en,
  input wire cmi_cmd_t i_cmd,
  input wire cmi_sw_t  i_sw,
  input wire logic     i_winch_on_boom,
  input wire cmi_cmd_t o_valve,
  input wire logic     o_pump,
  input wire logic     o_overload_trip,
  input wire logic     o_two_block_trip
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  int trip_cnt;  // edges the overload flag has stood high
  // counter spans the qualifier delay, too long for a repetition
  always_ff @(posedge i_sys_clk or posedge i_reset)
    if (i_reset) trip_cnt <= 0;
    else trip_cnt <= o_overload_trip ? trip_cnt + 1 : 0;
  // a level held long enough to cross sync and output stages
  sequence s_held(b); b[*5]; endsequence
  opp_off_a: assert property ((o_valve & (o_valve >> 1) & 8'h55) == 8'h0)
    else $error("opposing outputs both on");
  pump_follow_a: assert property (o_pump == |(o_valve & 8'h3f))
    else $error("pump does not follow valves");
  trip_block_a: assert property ((o_overload_trip || o_two_block_trip)
    |-> !o_valve.winch_up && !o_valve.extend_out) else $error("trip left damaging output");
  ovl_flag_a: assert property (s_held(!i_sw.overload_closed) |-> o_overload_trip)
    else $error("open overload switch not flagged");
  tb_flag_a: assert property (s_held(!i_sw.two_block_guard_switch) |-> o_two_block_trip)
    else $error("open two-block switch not flagged");
  safe_pass_a: assert property (s_held(i_cmd.winch_down && !i_cmd.winch_up)
    |-> o_valve.winch_down) else $error("hoist down blocked");
  hoist_idle_a: assert property (s_held(!i_cmd.winch_up && !i_cmd.winch_down)
    |-> !o_valve.winch_up && !o_valve.winch_down) else $error("hoist coil without command");
  hot_motor_a: assert property (s_held(!i_sw.thermal_closed) |-> !o_valve.winch_up)
    else $error("hoist up while motor hot");
  up_limit_a: assert property (s_held(!i_sw.up_limit_clear) |-> !o_valve.boom_up)
    else $error("boom up at limit");
  ovl_hold_a: assert property (o_overload_trip && trip_cnt >= DELAY_CYC
    |-> !o_valve.boom_down) else $error("boom down not blocked after delay");
endmodule // cmi_checker
bind cmi_interlock cmi_checker #(.DELAY_CYC(DELAY_CYC)) u_chk (.i_sys_clk(i_sys_clk),
  .i_reset(i_reset), .i_clk_en(i_clk_en), .i_cmd(i_cmd), .i_sw(i_sw),
  .i_winch_on_boom(i_winch_on_boom), .o_valve(o_valve), .o_pump(o_pump),
  .o_overload_trip(o_overload_trip), .o_two_block_trip(o_two_block_trip));

/* bench/cmi_pendant_model.sv */
// pendant and safety switch model driving the interlock pins
`timescale 1ns/1ps
module cmi_pendant_model
  import cmi_pkg::*;
(
  input  wire logic     i_sys_clk,
  input  wire cmi_cmd_t i_press,   // buttons the operator holds
  input  wire cmi_sw_t  i_health,  // switch levels, high is closed
  output cmi_cmd_t      o_cmd,
  output cmi_sw_t       o_sw
);
  initial o_cmd = '0;
  initial o_sw  = '0;
  // contacts move after the edge, so the design sees clean levels
  always @(posedge i_sys_clk)
  begin
    o_cmd <= i_press;
    o_sw  <= i_health;  // closed contact is the healthy level
  end
endmodule // cmi_pendant_model

/* bench/tb_top.sv */
// self-checking testbench for the crane motion interlock
`timescale 1ns/1ps
module tb_top;
  import cmi_pkg::*;
  localparam int unsigned DLY = 8;  // shortened overload delay
  logic     clk      = 1'h0;
  logic     rst      = 1'h1;
  logic     wob      = 1'h0;  // winch mounted on boom
  logic     en       = 1'h1;  // clock enable
  cmi_cmd_t press    = '0;
  cmi_sw_t  health   = 4'hf;
  cmi_cmd_t cmd, valve;
  cmi_sw_t  sw;
  logic     pump, ovl_trip, tb_trip;
  int       miscompares = 0;
  int       compares    = 0;
  cmi_pendant_model u_model (.i_sys_clk(clk), .i_press(press), .i_health(health),
    .o_cmd(cmd), .o_sw(sw));
  cmi_interlock #(.DELAY_CYC(DLY)) u_dut (.i_sys_clk(clk), .i_reset(rst), .i_clk_en(en),
    .i_cmd(cmd), .i_sw(sw), .i_winch_on_boom(wob), .o_valve(valve), .o_pump(pump),
    .o_overload_trip(ovl_trip), .o_two_block_trip(tb_trip));
  initial forever #20 clk = ~clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  // apply levels at a falling edge, wait n falling edges, judge outputs
  task automatic step(input cmi_cmd_t c, input cmi_sw_t s, input logic b, input int n,
                      input cmi_cmd_t e);
    press = c;
    health = s;
    wob = b;
    repeat (n) @(negedge clk);
    chk(valve, e, "valve");  // drive set per scenario
    chk({7'h0, pump}, {7'h0, |(e & 8'h3f)}, "pump");  // hoist never runs pump
  endtask
  task automatic t_basic;
    for (int i = 0; i < 8; i++)
      step(8'h1 << i, 4'hf, 1'h0, 6, 8'h1 << i);  // each direction alone
    step(8'h00, 4'hf, 1'h0, 6, 8'h00);  // nothing pressed
    step(8'haa, 4'hf, 1'h0, 6, 8'haa);  // several at once
    step(8'hff, 4'hf, 1'h0, 6, 8'h00);  // opposing pairs cancel
    $display("test basic done");
  endtask
  task automatic t_guards;
    step(8'haa, 4'hb, 1'h0, 6, 8'h22);  // two-block blocks
    chk({7'h0, tb_trip}, 8'h01, "tb flag");  // open is a trip
    step(8'h55, 4'hb, 1'h0, 6, 8'h45);  // safe ways pass, except boom down
    step(8'h55, 4'hb, 1'h1, 6, 8'h55);  // boom mounted winch
    step(8'haa, 4'hb, 1'h1, 6, 8'h22);  // still blocks others
    step(8'haa, 4'hd, 1'h0, 6, 8'h2a);  // hot motor
    step(8'h55, 4'hd, 1'h0, 6, 8'h55);  // hoist down while hot
    step(8'haa, 4'hf, 1'h0, 6, 8'haa);  // cooled again
    step(8'haa, 4'he, 1'h0, 6, 8'h8a);  // up limit
    $display("test guards done");
  endtask
  task automatic t_overload;
    step(8'haa, 4'h7, 1'h0, 6, 8'h22);  // overload blocks
    chk({7'h0, ovl_trip}, 8'h01, "ovl flag");  // open is a trip
    step(8'h55, 4'hf, 1'h0, 6, 8'h55);  // healthy again
    step(8'h55, 4'h7, 1'h0, 5, 8'h55);  // open, not yet qualified
    step(8'h55, 4'h7, 1'h0, 6, 8'h55);  // last cycle before qualification
    step(8'h55, 4'h7, 1'h0, 1, 8'h45);  // qualified trip
    step(8'h55, 4'hf, 1'h0, 4, 8'h55);  // no added delay
    $display("test overload done");
  endtask
  // clock enable freezes state; a mid-run reset clears outputs
  task automatic t_control;
    step(8'haa, 4'hf, 1'h0, 6, 8'haa);  // running set
    en = 1'h0;
    step(8'ha8, 4'hf, 1'h0, 6, 8'haa);  // frozen while enable low
    en = 1'h1;
    step(8'ha8, 4'hf, 1'h0, 6, 8'ha8);  // resumes with enable high
    rst = 1'h1;
    repeat (2) @(negedge clk);
    chk(valve, 8'h00, "mid reset");  // outputs clear in reset
    chk({7'h0, pump}, 8'h00, "mid reset pump");  // pump off in reset
    rst = 1'h0;
    step(8'ha8, 4'hf, 1'h0, 6, 8'ha8);  // back after reset
    $display("test control done");
  endtask
  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard: running out counts as a mismatch
  initial
  begin
    #4000000;
    miscompares++;
    end_of_test;
  end
  initial
  begin
    repeat (10) @(negedge clk);
    chk(valve, 8'h00, "reset");  // outputs clear in reset
    rst = 1'h0;
    t_basic;
    t_guards;
    t_overload;
    t_control;
    end_of_test;
  end
endmodule // tb_top
